// file: shared/ppsc_pkg.sv
// Constants and types for the parallel port status and control slice
package ppsc_pkg;

   // -----------------------------------------------------------------
   // Register offsets and reset values
   // -----------------------------------------------------------------
   localparam logic [2:0] OFS_STATUS  = 3'h1;
   localparam logic [2:0] OFS_CONTROL = 3'h2;
   localparam logic [7:0] CTRL_RESET  = 8'hC0;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int STS_BUSY_BIT  = 7;
   localparam int STS_ACK_BIT   = 6;
   localparam int STS_PAPER_BIT = 5;
   localparam int STS_SEL_BIT   = 4;
   localparam int STS_FAULT_BIT = 3;
   localparam int STS_TMO_BIT   = 0;
   localparam int CTL_DIR_BIT   = 5;
   localparam int CTL_IRQEN_BIT = 4;

   // Lane order of the synchronised peripheral inputs
   localparam int SYN_BUSY  = 0;
   localparam int SYN_ACK   = 1;
   localparam int SYN_PAPER = 2;
   localparam int SYN_SEL   = 3;
   localparam int SYN_FAULT = 4;
   localparam int SYN_LANES = 5;

   // -----------------------------------------------------------------
   // Port modes
   // -----------------------------------------------------------------
   localparam logic [2:0] MODE_SPP      = 3'h0;
   localparam logic [2:0] MODE_SPP_EXT  = 3'h1;
   localparam logic [2:0] MODE_EPP      = 3'h2;
   localparam logic [2:0] MODE_ECP      = 3'h3;
   localparam logic [2:0] MODE_PP_FIFO  = 3'h4;
   localparam logic [2:0] MODE_TEST_FIF = 3'h5;

   // Nibble reverse transfer phase
   typedef enum logic [1:0] {
      NIB_LOW  = 2'b01,
      NIB_HIGH = 2'b10
   } nib_phase_e;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 100;
   localparam int EPP_TIMEOUT_NS = 10000;
   localparam int TMO_CYCLES_INT =
      (EPP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] TMO_CYCLES = 8'(TMO_CYCLES_INT);
   localparam logic [7:0] TMO_ZERO   = 8'h00;
   localparam logic [7:0] TMO_ONE    = 8'h01;

endpackage

// file: hw/sync_two_flop.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s st_q;
   sync_s st_d;

   // First stage feeds only the second stage
   always_comb begin
      st_d        = st_q;
      st_d.meta   = asyncIn;
      st_d.stable = st_q.meta;
   end

   // Both stages clear to zero; inputs settle within two edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign syncOut = st_q.stable;

   // Output is the input delayed by exactly two edges
   syncDelay_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ##2 syncOut == $past(asyncIn, 2))
      else $error("synchroniser output not two cycles behind input");

endmodule

// file: hw/epp_timeout_timer.sv
// Watchdog that flags an EPP cycle running past the minimum timeout
`timescale 1ns/1ps
module epp_timeout_timer (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic cycleActive,
   output logic      expire
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
      logic       expire;
   } tmo_s;

   tmo_s st_q;
   tmo_s st_d;

   // Count active cycles; fire once, then saturate until the cycle ends
   always_comb begin
      st_d        = st_q;
      st_d.expire = 1'b0;
      if (!cycleActive) begin
         st_d.count = ppsc_pkg::TMO_ZERO;
      end else if (st_q.count != ppsc_pkg::TMO_CYCLES) begin
         st_d.count = st_q.count + ppsc_pkg::TMO_ONE;
         if (st_q.count == ppsc_pkg::TMO_CYCLES - ppsc_pkg::TMO_ONE) begin
            st_d.expire = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign expire = st_q.expire;

   // Expiry only after the full minimum time of activity
   tmoMinTime_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(expire) |-> st_q.count == ppsc_pkg::TMO_CYCLES)
      else $error("timeout fired before the minimum time");

   // Expiry is a single-cycle pulse
   tmoPulse_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      expire |=> !expire)
      else $error("timeout pulse longer than one cycle");

endmodule

// file: hw/parallel_port_status_control.sv
// Status and control registers of a host parallel port controller
`timescale 1ns/1ps
module parallel_port_status_control (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] regAddr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStrobe,
   input  wire logic       rdStrobe,
   output logic      [7:0] rdData,
   input  wire logic [2:0] portMode,
   input  wire logic       dmaMode,
   input  wire logic       nibbleMode,
   input  wire logic       eppCycleActive,
   input  wire logic       busyIn,
   input  wire logic       ackIn_n,
   input  wire logic       paperOut,
   input  wire logic       peripheralSelected,
   input  wire logic       faultIn_n,
   output logic      [7:0] ctrlLines,
   output logic            irqPulse,
   output logic      [7:0] nibbleData,
   output logic            nibbleValid
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]           ctrl;
      logic                 tmoFlag;
      logic [7:0]           rdData;
      logic                 ackPrev;
      logic                 irq;
      ppsc_pkg::nib_phase_e phase;
      logic [3:0]           lowNib;
      logic [7:0]           nibData;
      logic                 nibValid;
   } state_s;

   state_s                         st_q;
   state_s                         st_d;
   logic [ppsc_pkg::SYN_LANES-1:0] rawLines;
   logic [ppsc_pkg::SYN_LANES-1:0] syncLines;
   logic                           tmoExpire;
   logic                           eppMode;
   logic                           dirReadZero;
   logic                           statusRead;
   logic                           statusWrite;
   logic                           ctrlWrite;
   logic                           ackRise;
   logic                           tmoBecomesSet;
   logic [7:0]                     statusByte;
   logic [7:0]                     ctrlByte;
   logic [3:0]                     curNib;

   // -----------------------------------------------------------------
   // Input synchronisation and timeout watchdog
   // -----------------------------------------------------------------
   // Cable lines are asynchronous to the core clock. Active-low lines
   // are turned active-high first, so the zero reset of the
   // synchroniser matches an idle cable and no false acknowledge
   // release is seen just after reset.
   assign rawLines = {~faultIn_n, peripheralSelected, paperOut,
                      ~ackIn_n, busyIn};

   sync_two_flop #(
      .WIDTH (ppsc_pkg::SYN_LANES)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .asyncIn  (rawLines),
      .syncOut  (syncLines)
   );

   // Watchdog only runs while an EPP cycle is in flight
   epp_timeout_timer u_tmo (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .cycleActive (eppCycleActive && eppMode),
      .expire      (tmoExpire)
   );

   // -----------------------------------------------------------------
   // Decode and read values
   // -----------------------------------------------------------------
   assign eppMode     = (portMode == ppsc_pkg::MODE_EPP);
   // Direction bit is write-only in these modes and reads as zero
   assign dirReadZero = (portMode == ppsc_pkg::MODE_SPP) ||
                        (portMode == ppsc_pkg::MODE_PP_FIFO);
   assign statusRead  = rdStrobe && (regAddr == ppsc_pkg::OFS_STATUS);
   assign statusWrite = wrStrobe && (regAddr == ppsc_pkg::OFS_STATUS);
   assign ctrlWrite   = wrStrobe && (regAddr == ppsc_pkg::OFS_CONTROL);
   // Acknowledge going back inactive marks a taken character; the
   // lane holds the asserted level, so a release is a falling lane
   assign ackRise     = !syncLines[ppsc_pkg::SYN_ACK] && st_q.ackPrev;
   assign tmoBecomesSet = tmoExpire && !st_q.tmoFlag;

   // Live status byte; reserved bits read zero
   always_comb begin
      statusByte = ppsc_pkg::BYTE_ZERO;
      statusByte[ppsc_pkg::STS_BUSY_BIT] =
         !syncLines[ppsc_pkg::SYN_BUSY];
      statusByte[ppsc_pkg::STS_ACK_BIT] =
         !syncLines[ppsc_pkg::SYN_ACK];
      statusByte[ppsc_pkg::STS_PAPER_BIT] =
         syncLines[ppsc_pkg::SYN_PAPER];
      statusByte[ppsc_pkg::STS_SEL_BIT] =
         syncLines[ppsc_pkg::SYN_SEL];
      statusByte[ppsc_pkg::STS_FAULT_BIT] =
         !syncLines[ppsc_pkg::SYN_FAULT];
      // Outside EPP the flag is hidden to keep the value meaningful
      statusByte[ppsc_pkg::STS_TMO_BIT] = eppMode && st_q.tmoFlag;
   end

   // Control readback with the direction bit masked per mode
   always_comb begin
      ctrlByte = st_q.ctrl;
      if (dirReadZero) begin
         ctrlByte[ppsc_pkg::CTL_DIR_BIT] = 1'b0;
      end
   end

   // Nibble carried on busy, paper, select and fault
   assign curNib = {statusByte[ppsc_pkg::STS_BUSY_BIT],
                    statusByte[ppsc_pkg::STS_PAPER_BIT],
                    statusByte[ppsc_pkg::STS_SEL_BIT],
                    statusByte[ppsc_pkg::STS_FAULT_BIT]};

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      st_d          = st_q;
      st_d.irq      = 1'b0;
      st_d.nibValid = 1'b0;
      st_d.ackPrev  = syncLines[ppsc_pkg::SYN_ACK];

      // Read data stand only in the cycle after the strobe
      st_d.rdData = ppsc_pkg::BYTE_ZERO;
      if (rdStrobe) begin
         case (regAddr)
            ppsc_pkg::OFS_STATUS: begin
               st_d.rdData = statusByte;
            end
            ppsc_pkg::OFS_CONTROL: begin
               st_d.rdData = ctrlByte;
            end
            default: begin
               st_d.rdData = ppsc_pkg::BYTE_ZERO;
            end
         endcase
      end

      // All control bits are stored; bit 5 masking is on read only
      if (ctrlWrite) begin
         st_d.ctrl = wrData;
      end

      // Clear on read; a write to bit 0 is ignored. A timeout in the
      // same cycle as the read wins so the event is never lost.
      if (statusRead) begin
         st_d.tmoFlag = 1'b0;
      end
      if (tmoExpire) begin
         st_d.tmoFlag = 1'b1;
      end

      // Interrupt on acknowledge release or timeout becoming set
      if (st_q.ctrl[ppsc_pkg::CTL_IRQEN_BIT] &&
          ((ackRise && !dmaMode) || (tmoBecomesSet && eppMode))) begin
         st_d.irq = 1'b1;
      end

      // Each status read in nibble mode takes one nibble, low first
      if (!nibbleMode) begin
         st_d.phase = ppsc_pkg::NIB_LOW;
      end else if (statusRead) begin
         case (st_q.phase)
            ppsc_pkg::NIB_LOW: begin
               st_d.lowNib = curNib;
               st_d.phase  = ppsc_pkg::NIB_HIGH;
            end
            ppsc_pkg::NIB_HIGH: begin
               st_d.nibData  = {curNib, st_q.lowNib};
               st_d.nibValid = 1'b1;
               st_d.phase    = ppsc_pkg::NIB_LOW;
            end
            default: begin
               st_d.phase = ppsc_pkg::NIB_LOW;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q          <= '0;
         st_q.ctrl     <= ppsc_pkg::CTRL_RESET;
         st_q.ackPrev  <= 1'b0; // Idle cable: acknowledge not asserted
         st_q.phase    <= ppsc_pkg::NIB_LOW;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdData      = st_q.rdData;
   assign ctrlLines   = st_q.ctrl;
   assign irqPulse    = st_q.irq;
   assign nibbleData  = st_q.nibData;
   assign nibbleValid = st_q.nibValid;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence stsRead_s;
      rdStrobe && regAddr == ppsc_pkg::OFS_STATUS;
   endsequence

   sequence ackRelease_s;
      syncLines[ppsc_pkg::SYN_ACK] ##1 !syncLines[ppsc_pkg::SYN_ACK];
   endsequence

   busyBit_a: assert property (
      stsRead_s |=> rdData[7] == !$past(syncLines[ppsc_pkg::SYN_BUSY]))
      else $error("busy bit not inverted busy line");

   ackBit_a: assert property (
      stsRead_s |=> rdData[6] == !$past(syncLines[ppsc_pkg::SYN_ACK]))
      else $error("ack bit does not follow line");

   paperSel_a: assert property (
      stsRead_s |=> rdData[5:4] ==
         {$past(syncLines[ppsc_pkg::SYN_PAPER]),
          $past(syncLines[ppsc_pkg::SYN_SEL])})
      else $error("paper or select bit wrong");

   faultRsv_a: assert property (
      stsRead_s |=> rdData[3:1] ==
         {!$past(syncLines[ppsc_pkg::SYN_FAULT]), 2'b00})
      else $error("fault or reserved bits wrong");

   tmoSet_a: assert property (
      tmoExpire |=> st_q.tmoFlag)
      else $error("timeout flag not set after expiry");

   tmoClear_a: assert property (
      stsRead_s ##0 !tmoExpire |=> !st_q.tmoFlag)
      else $error("timeout flag not cleared by read");

   tmoWrite_a: assert property (
      statusWrite && st_q.tmoFlag |=> st_q.tmoFlag)
      else $error("write disturbed timeout flag");

   ctrlWrite_a: assert property (
      ctrlWrite && !dirReadZero ##1 rdStrobe &&
      regAddr == ppsc_pkg::OFS_CONTROL |=> rdData == $past(wrData, 2))
      else $error("control readback differs from write");

   dirZero_a: assert property (
      rdStrobe && regAddr == ppsc_pkg::OFS_CONTROL && dirReadZero
      |=> !rdData[ppsc_pkg::CTL_DIR_BIT])
      else $error("direction bit not read as zero");

   ackIrq_a: assert property (
      ackRelease_s ##0 (st_q.ctrl[ppsc_pkg::CTL_IRQEN_BIT] && !dmaMode)
      |=> irqPulse)
      else $error("no interrupt on acknowledge release");

   irqMask_a: assert property (
      !st_q.ctrl[ppsc_pkg::CTL_IRQEN_BIT] |=> !irqPulse)
      else $error("interrupt raised while masked");

   nibPair_a: assert property (
      (nibbleMode && st_q.phase == ppsc_pkg::NIB_HIGH) and stsRead_s
      |=> nibbleValid && nibbleData[3:0] == $past(st_q.lowNib))
      else $error("nibble byte not assembled low first");

   // Timeout becoming set raises the interrupt when enabled
   tmoIrq_a: assert property (
      tmoExpire && !st_q.tmoFlag && eppMode &&
      st_q.ctrl[ppsc_pkg::CTL_IRQEN_BIT] |=> irqPulse)
      else $error("no interrupt on timeout becoming set");

   // Read data stand one cycle only; the bus sees zero otherwise
   rdIdle_a: assert property (
      !rdStrobe |=> rdData == ppsc_pkg::BYTE_ZERO)
      else $error("read data present without a read");

endmodule

// file: bench/ppsc_peripheral.sv
// Behavioural printer on the cable side of the parallel port
`timescale 1ns/1ps
module ppsc_peripheral (
   input  wire logic       core_clk,
   input  wire logic [3:0] lineReq,
   input  wire logic       ackReq,
   output logic            busyIn,
   output logic            ackIn_n,
   output logic            paperOut,
   output logic            peripheralSelected,
   output logic            faultIn_n
);
   // Idle cable at time zero: not busy, no acknowledge, no fault
   initial begin
      busyIn = 1'b0;
      ackIn_n = 1'b1;
      paperOut = 1'b0;
      peripheralSelected = 1'b0;
      faultIn_n = 1'b1;
   end

   // Lines move 37 ns after the edge, so they never meet the sampling edge
   always @(posedge core_clk) begin
      busyIn             <= #37 lineReq[3];
      paperOut           <= #37 lineReq[2];
      peripheralSelected <= #37 lineReq[1];
      faultIn_n          <= #37 lineReq[0];
   end

   // Acknowledge: high, low for four cycles, high again
   always @(posedge ackReq) begin
      #37 ackIn_n = 1'b0;
      repeat (4) @(posedge core_clk);
      #37 ackIn_n = 1'b1;
   end
endmodule

// file: bench/parallel_port_status_control_bench.sv
// Self-checking bench for the parallel port status and control slice
`timescale 1ns/1ps
module parallel_port_status_control_bench;
   logic       core_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] wrData = 8'h00;
   logic       wrStrobe = 1'b0;
   logic       rdStrobe = 1'b0;
   logic [2:0] portMode = 3'h0;
   logic       dmaMode = 1'b0;
   logic       nibbleMode = 1'b0;
   logic       eppCycleActive = 1'b0;
   logic [3:0] lineReq = 4'h1;
   logic       ackReq = 1'b0;
   wire        busyIn, ackIn_n, paperOut, peripheralSelected, faultIn_n;
   logic [7:0] rdData, ctrlLines, nibbleData, d, v, ndSeen;
   logic       irqPulse, nibbleValid, nvSeen, got;
   int         miscompares = 0;
   int         nTests = 0;
   int         seed, i, c;

   always #50 core_clk = ~core_clk;

   parallel_port_status_control i_parallel_port_status_control (
      .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
      .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .rdData(rdData), .portMode(portMode), .dmaMode(dmaMode),
      .nibbleMode(nibbleMode), .eppCycleActive(eppCycleActive),
      .busyIn(busyIn), .ackIn_n(ackIn_n), .paperOut(paperOut),
      .peripheralSelected(peripheralSelected), .faultIn_n(faultIn_n),
      .ctrlLines(ctrlLines), .irqPulse(irqPulse),
      .nibbleData(nibbleData), .nibbleValid(nibbleValid));

   ppsc_peripheral i_ppsc_peripheral (
      .core_clk(core_clk), .lineReq(lineReq), .ackReq(ackReq),
      .busyIn(busyIn), .ackIn_n(ackIn_n), .paperOut(paperOut),
      .peripheralSelected(peripheralSelected), .faultIn_n(faultIn_n));

   // -----------------------------------------------------------------
   // Expectations and bus tasks
   // -----------------------------------------------------------------
   // lineReq is {busy, paper out, selected, fault_n}
   function automatic logic [7:0] expStatus(logic [3:0] l, logic a,
                                            logic t);
      return {~l[3], a, l[2], l[1], l[0], 2'b00, t};
   endfunction

   function automatic logic [7:0] expCtrl(logic [7:0] w, logic [2:0] m);
      logic [7:0] r;
      r = w;
      if (m == ppsc_pkg::MODE_SPP || m == ppsc_pkg::MODE_PP_FIFO) begin
         r[ppsc_pkg::CTL_DIR_BIT] = 1'b0;
      end
      return r;
   endfunction

   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(logic [2:0] a, logic [7:0] w);
      @(posedge core_clk);
      regAddr <= a;
      wrData <= w;
      wrStrobe <= 1'b1;
      @(posedge core_clk);
      wrStrobe <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe: taken there
   task automatic rd(logic [2:0] a, output logic [7:0] r);
      @(posedge core_clk);
      regAddr <= a;
      rdStrobe <= 1'b1;
      @(posedge core_clk);
      rdStrobe <= 1'b0;
      @(negedge core_clk);
      r = rdData;
      nvSeen = nibbleValid;
      ndSeen = nibbleData;
   endtask

   // Write, then read the same offset with no gap between strobes
   task automatic wrRd(logic [2:0] a, logic [7:0] w,
                       output logic [7:0] r);
      wr(a, w);
      rdStrobe <= 1'b1;
      @(posedge core_clk);
      rdStrobe <= 1'b0;
      @(negedge core_clk);
      r = rdData;
   endtask

   task automatic countIrq(int n, output int k);
      k = 0;
      repeat (n) begin
         @(negedge core_clk);
         if (irqPulse === 1'b1) k++;
      end
   endtask

   task automatic setLines(logic [3:0] l);
      @(posedge core_clk);
      lineReq <= l;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic tallyAndFinish();
      $display("comparisons %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Hang guard well beyond the longest sequence
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      tallyAndFinish();
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      seed = 32'h4AE0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("ctrl reset", ctrlLines, ppsc_pkg::CTRL_RESET);
      chk("rd idle", rdData, ppsc_pkg::BYTE_ZERO);
      // Every mode: control stored whole, direction bit masked on reads in SPP and PP FIFO modes
      for (i = 0; i < 6; i++) begin
         @(posedge core_clk);
         portMode <= 3'(i);
         v = 8'($random(seed));
         wrRd(ppsc_pkg::OFS_CONTROL, v, d);
         chk("ctrl lines", ctrlLines, v);
         chk("ctrl read", d, expCtrl(v, 3'(i)));
      end
      $display("control test done");
      // Random live lines outside EPP: timeout bit reads 0
      @(posedge core_clk);
      portMode <= ppsc_pkg::MODE_SPP_EXT;
      for (i = 0; i < 16; i++) begin
         setLines(4'($random(seed)));
         rd(ppsc_pkg::OFS_STATUS, d);
         chk("status", d, expStatus(lineReq, 1'b1, 1'b0));
      end
      // Unmapped offsets read 0 and leave control untouched
      wr(ppsc_pkg::OFS_CONTROL, 8'hC0);
      for (i = 3; i < 9; i++) begin
         wr(3'(i), 8'hFF);
         rd(3'(i), d);
         chk("unmapped", d, ppsc_pkg::BYTE_ZERO);
      end
      chk("ctrl kept", ctrlLines, 8'hC0);
      $display("status test done");
      // Acknowledge pulse: live low, then interrupt per enable and DMA
      for (i = 0; i < 3; i++) begin
         @(posedge core_clk);
         dmaMode <= (i == 1);
         wr(ppsc_pkg::OFS_CONTROL, (i == 2) ? 8'hC0 : 8'hD0);
         @(posedge core_clk);
         ackReq <= 1'b1;
         @(posedge core_clk);
         ackReq <= 1'b0;
         rd(ppsc_pkg::OFS_STATUS, d);
         chk("ack low", {7'h00, d[ppsc_pkg::STS_ACK_BIT]}, 8'h00);
         countIrq(14, c);
         chk("ack irq", 8'(c), (i == 0) ? 8'h01 : 8'h00);
      end
      $display("acknowledge test done");
      // EPP timeout: short span stays clear, long span sets and irqs
      @(posedge core_clk);
      dmaMode <= 1'b0;
      portMode <= ppsc_pkg::MODE_EPP;
      wr(ppsc_pkg::OFS_CONTROL, 8'hD0);
      @(posedge core_clk);
      eppCycleActive <= 1'b1;
      countIrq(60, c);
      @(posedge core_clk);
      eppCycleActive <= 1'b0;
      rd(ppsc_pkg::OFS_STATUS, d);
      chk("short span", {7'h00, d[0]} | 8'(c), 8'h00);
      @(posedge core_clk);
      eppCycleActive <= 1'b1;
      got = 1'b0;
      c = 0;
      while (!got && c < 130) begin
         @(negedge core_clk);
         c++;
         got = (irqPulse === 1'b1);
      end
      chk("tmo irq", {7'h00, got}, 8'h01);
      chk("tmo length", {7'h00, c >= ppsc_pkg::TMO_CYCLES_INT}, 8'h01);
      @(posedge core_clk);
      eppCycleActive <= 1'b0;
      wr(ppsc_pkg::OFS_STATUS, 8'h00);
      rd(ppsc_pkg::OFS_STATUS, d);
      chk("tmo set", d, expStatus(lineReq, 1'b1, 1'b1));
      rd(ppsc_pkg::OFS_STATUS, d);
      chk("tmo clear", d, expStatus(lineReq, 1'b1, 1'b0));
      $display("timeout test done");
      // Nibble reverse: two status reads assemble one byte
      @(posedge core_clk);
      portMode <= ppsc_pkg::MODE_SPP_EXT;
      nibbleMode <= 1'b1;
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hFF : ((i == 1) ? 8'h00 : 8'($random(seed)));
         setLines({~v[3], v[2:0]});
         rd(ppsc_pkg::OFS_STATUS, d);
         chk("nib first", {7'h00, nvSeen}, 8'h00);
         setLines({~v[7], v[6:4]});
         rd(ppsc_pkg::OFS_STATUS, d);
         chk("nib valid", {7'h00, nvSeen}, 8'h01);
         chk("nib data", ndSeen, v);
      end
      $display("nibble test done");
      tallyAndFinish();
   end
endmodule
